/* File: inc/atad_regs.vh */
// Purpose: Constants for the card host access decoder.
// Assumes: Attribute addresses are byte addresses on the card address bus.
// Notes: Included by the decoder only; the lane steering module does not include it.
`ifndef ATAD_REGS_VH
`define ATAD_REGS_VH
// ==========================================================================
// Configuration option register
`define ATAD_COR_ADDR 11'h200
`define ATAD_COR_RESET 8'h00
`define ATAD_COR_SRST_BIT 7
`define ATAD_COR_LEVI_BIT 6
`define ATAD_COR_IDX_MSB 5
// ==========================================================================
// Mapping index values
`define ATAD_IDX_MEM 6'h00
`define ATAD_IDX_CONTIG 6'h01
`define ATAD_IDX_PRIMARY 6'h02
`define ATAD_IDX_SECONDARY 6'h03
// ==========================================================================
// Task file windows
`define ATAD_PRI_BASE 11'h1F0
`define ATAD_PRI_ALT 11'h3F6
`define ATAD_SEC_BASE 11'h170
`define ATAD_SEC_ALT 11'h376
`define ATAD_MEM_HI_BASE 11'h400
// ==========================================================================
// True IDE decode
`define ATAD_IDE_ALT_ADDR 3'h6
`define ATAD_IDE_DATA_ADDR 3'h0
// ==========================================================================
// Timing
`define ATAD_CLK_NS 25
`define ATAD_IRQ_PULSE_NS 100
`endif

/* File: rtl/atad_lane.v */
// Purpose: Byte lane steering for card mode task file transfers.
// Assumes: Enables are active high; the caller qualifies the outputs, not the enables.
// Notes: Purely combinational; the top module registers every output.
`timescale 1ns/100ps
module atad_lane
(
	input wire low_en_in,
	input wire high_en_in,
	input wire a0_in,
	input wire [15:0] wdata_in,
	input wire [7:0] even_rd_in,
	input wire [7:0] odd_rd_in,
	output reg [15:0] rdata_out,
	output reg [1:0] rd_oe_out,
	output reg [7:0] wr_byte_out,
	output reg wr_odd_out,
	output reg [7:0] wr_hi_byte_out,
	output reg wr_hi_out
);
	// ==========================================================================
	// Lane selection
	always @*
	begin
		rdata_out = 16'h0000;
		rd_oe_out = 2'b00;
		wr_byte_out = 8'h00;
		wr_odd_out = 1'b0;
		wr_hi_byte_out = 8'h00;
		wr_hi_out = 1'b0;
		if (low_en_in && !high_en_in)
		begin
			rd_oe_out = 2'b01;
			rdata_out[7:0] = a0_in ? odd_rd_in : even_rd_in;
			wr_byte_out = wdata_in[7:0];
			wr_odd_out = a0_in;
		end
		else if (low_en_in && high_en_in)
		begin
			rd_oe_out = 2'b11;
			rdata_out = {odd_rd_in, even_rd_in};
			wr_byte_out = wdata_in[7:0];
			wr_odd_out = 1'b0;
			wr_hi_byte_out = wdata_in[15:8];
			wr_hi_out = 1'b1;
		end
		else if (!low_en_in && high_en_in)
		begin
			rd_oe_out = 2'b10;
			rdata_out[15:8] = odd_rd_in;
			wr_hi_byte_out = wdata_in[15:8];
			wr_hi_out = 1'b1;
		end
	end
endmodule

/* File: rtl/atad_decoder.v */
// Purpose: Host access decoder of a removable ATA flash card.
// Assumes: Host strobes are synchronous to CLK_IN; task file storage lives elsewhere.
// Notes: The task file itself is reached through the TF_* ports.
`timescale 1ns/100ps
`include "atad_regs.vh"
module atad_decoder
#(
	parameter AW = 11
)
(
	input wire CLK_IN,
	input wire RST_IN,
	input wire CARD_RESET_IN,
	input wire ATTR_SELECT_N_IN,
	input wire LOW_BYTE_CARD_ENABLE_N_IN,
	input wire HIGH_BYTE_CARD_ENABLE_N_IN,
	input wire OUTPUT_ENABLE_N_IN,
	input wire WRITE_ENABLE_N_IN,
	input wire IO_READ_STROBE_N_IN,
	input wire IO_WRITE_STROBE_N_IN,
	input wire [AW-1:0] ADDR_IN,
	input wire [15:0] DATA_IN,
	input wire [7:0] CIS_DATA_IN,
	input wire [7:0] TF_EVEN_DATA_IN,
	input wire [7:0] TF_ODD_DATA_IN,
	input wire BYTE_MODE_SET_IN,
	input wire BYTE_MODE_CLEAR_IN,
	input wire IRQ_EVENT_IN,
	input wire IRQ_ACTIVE_IN,
	output reg [15:0] DATA_OUT,
	output reg [1:0] DATA_OE_OUT,
	output reg SIXTEEN_BIT_IO_INDICATOR_N_OUT,
	output reg [3:0] TF_INDEX_OUT,
	output reg TF_RD_OUT,
	output reg TF_WR_OUT,
	output reg [1:0] TF_WR_LANES_OUT,
	output reg [15:0] TF_WDATA_OUT,
	output reg TF_ALT_OUT,
	output reg TF_CTRL_OUT,
	output reg CARD_RESET_OUT,
	output reg TRUE_IDE_OUT,
	output reg LEVEL_IRQ_OUT,
	output reg IRQ_OUT,
	output reg [5:0] MAP_INDEX_OUT
);
	// ==========================================================================
	// Local definitions
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_ACCESS = 2'b01;
	localparam [1:0] ST_HOLD = 2'b10;
	localparam integer PULSE_CYC = (`ATAD_IRQ_PULSE_NS + `ATAD_CLK_NS - 1) / `ATAD_CLK_NS;

	// Checks an address against an aligned window of the given size.
	function in_win;
		input [AW-1:0] a;
		input [AW-1:0] base;
		input [AW-1:0] size;
		begin
			in_win = (a >= base) && (a < base + size);
		end
	endfunction

	// ==========================================================================
	// State
	reg soft_reset_bit_r;
	reg level_interrupt_select_r;
	reg [5:0] map_index_r;
	reg true_ide_r;
	reg byte_mode_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [2:0] pulse_cnt_r;
	reg card_reset_d_r;

	// ==========================================================================
	// Access qualification
	wire low_en = !LOW_BYTE_CARD_ENABLE_N_IN;
	wire high_en = !HIGH_BYTE_CARD_ENABLE_N_IN;
	wire any_en = low_en || high_en;
	wire attr = !ATTR_SELECT_N_IN;
	wire io_rd = !IO_READ_STROBE_N_IN;
	wire io_wr = !IO_WRITE_STROBE_N_IN;
	wire io_idle = IO_READ_STROBE_N_IN && IO_WRITE_STROBE_N_IN;
	wire mem_rd = !OUTPUT_ENABLE_N_IN && WRITE_ENABLE_N_IN && io_idle;
	wire mem_wr = !WRITE_ENABLE_N_IN && OUTPUT_ENABLE_N_IN && io_idle;
	wire io_mode = (map_index_r != `ATAD_IDX_MEM);
	wire hard_reset = CARD_RESET_IN || soft_reset_bit_r;
	localparam [AW-1:0] COR_ADDR = `ATAD_COR_ADDR;
	wire cor_hit = (ADDR_IN[AW-1:1] == COR_ADDR[AW-1:1]);

	// Attribute space: configuration and card info structure.
	wire attr_rd = !true_ide_r && attr && mem_rd && any_en;
	wire attr_wr = !true_ide_r && attr && mem_wr && low_en;
	wire attr_even = low_en && !(ADDR_IN[0] && !high_en);

	// Task file window by mapping index.
	reg tf_hit;
	reg [3:0] tf_idx;
	always @*
	begin
		tf_hit = 1'b0;
		tf_idx = ADDR_IN[3:0];
		case (map_index_r)
			`ATAD_IDX_MEM:
			begin
				tf_hit = in_win(ADDR_IN, {AW{1'b0}}, 11'h010) || ADDR_IN[AW-1:10] == 1'b1;
				if (ADDR_IN[AW-1:10] == 1'b1)
				begin
					tf_idx = ADDR_IN[0] ? 4'h9 : 4'h8;
				end
			end
			`ATAD_IDX_CONTIG:
			begin
				tf_hit = 1'b1;
			end
			`ATAD_IDX_PRIMARY:
			begin
				tf_hit = in_win(ADDR_IN, `ATAD_PRI_BASE, 11'h008) || in_win(ADDR_IN, `ATAD_PRI_ALT, 11'h002);
				if (in_win(ADDR_IN, `ATAD_PRI_ALT, 11'h002))
				begin
					tf_idx = {3'b111, ADDR_IN[0]};
				end
			end
			`ATAD_IDX_SECONDARY:
			begin
				tf_hit = in_win(ADDR_IN, `ATAD_SEC_BASE, 11'h008) || in_win(ADDR_IN, `ATAD_SEC_ALT, 11'h002);
				if (in_win(ADDR_IN, `ATAD_SEC_ALT, 11'h002))
				begin
					tf_idx = {3'b111, ADDR_IN[0]};
				end
			end
			default:
			begin
				tf_hit = 1'b0;
			end
		endcase
	end

	// Card task file cycles in memory or I/O card mode.
	wire card_tf_rd = !true_ide_r && any_en && tf_hit &&
		(io_mode ? (attr && io_rd && IO_WRITE_STROBE_N_IN) : (!attr && mem_rd));
	wire card_tf_wr = !true_ide_r && any_en && tf_hit &&
		(io_mode ? (attr && io_wr && IO_READ_STROBE_N_IN) : (!attr && mem_wr));

	// True IDE cycles; both enables low is invalid and ignored.
	wire ide_low = low_en && !high_en;
	wire ide_alt = high_en && !low_en && ADDR_IN[2:0] == `ATAD_IDE_ALT_ADDR;
	wire ide_rd = true_ide_r && io_rd && IO_WRITE_STROBE_N_IN && (ide_low || ide_alt);
	wire ide_wr = true_ide_r && io_wr && IO_READ_STROBE_N_IN && (ide_low || ide_alt);
	wire ide_data = ide_low && ADDR_IN[2:0] == `ATAD_IDE_DATA_ADDR;

	// ==========================================================================
	// Lane steering
	wire [15:0] lane_rdata;
	wire [1:0] lane_oe;
	wire [7:0] lane_wbyte;
	wire lane_wodd;
	wire [7:0] lane_whi;
	wire lane_whi_en;
	atad_lane u_lane
	(
		.low_en_in(low_en),
		.high_en_in(high_en),
		.a0_in(ADDR_IN[0]),
		.wdata_in(DATA_IN),
		.even_rd_in(TF_EVEN_DATA_IN),
		.odd_rd_in(TF_ODD_DATA_IN),
		.rdata_out(lane_rdata),
		.rd_oe_out(lane_oe),
		.wr_byte_out(lane_wbyte),
		.wr_odd_out(lane_wodd),
		.wr_hi_byte_out(lane_whi),
		.wr_hi_out(lane_whi_en)
	);

	// ==========================================================================
	// Access sequencing: one write effect per strobe assertion.
	wire any_wr = attr_wr || card_tf_wr || ide_wr;
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (any_wr)
				begin
					state_nxt = ST_ACCESS;
				end
			end
			ST_ACCESS:
			begin
				state_nxt = ST_HOLD;
			end
			ST_HOLD:
			begin
				if (!any_wr)
				begin
					state_nxt = ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end
	wire wr_fire = (state_r == ST_IDLE) && any_wr;

	// ==========================================================================
	// Configuration option register
	always @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			soft_reset_bit_r <= 1'b0;
			level_interrupt_select_r <= 1'b0;
			map_index_r <= `ATAD_IDX_MEM;
		end
		else if (CARD_RESET_IN)
		begin
			soft_reset_bit_r <= 1'b0;
			level_interrupt_select_r <= 1'b0;
			map_index_r <= `ATAD_IDX_MEM;
		end
		else if (wr_fire && attr_wr && cor_hit && attr_even)
		begin
			soft_reset_bit_r <= DATA_IN[`ATAD_COR_SRST_BIT];
			level_interrupt_select_r <= (soft_reset_bit_r || DATA_IN[`ATAD_COR_SRST_BIT]) ? 1'b0 :
				DATA_IN[`ATAD_COR_LEVI_BIT];
			map_index_r <= (soft_reset_bit_r || DATA_IN[`ATAD_COR_SRST_BIT]) ? `ATAD_IDX_MEM :
				DATA_IN[`ATAD_COR_IDX_MSB:0];
		end
		else if (soft_reset_bit_r)
		begin
			level_interrupt_select_r <= 1'b0;
			map_index_r <= `ATAD_IDX_MEM;
		end
	end

	// ==========================================================================
	// Mode and transfer width
	always @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			true_ide_r <= 1'b0;
			byte_mode_r <= 1'b0;
			card_reset_d_r <= 1'b0;
			state_r <= ST_IDLE;
		end
		else
		begin
			state_r <= state_nxt;
			card_reset_d_r <= CARD_RESET_IN;
			// Mode is latched as reset ends so a moving output enable cannot flip it mid-session.
			if (card_reset_d_r && !CARD_RESET_IN)
			begin
				true_ide_r <= !OUTPUT_ENABLE_N_IN;
			end
			if (hard_reset)
			begin
				byte_mode_r <= 1'b0;
			end
			else if (BYTE_MODE_SET_IN)
			begin
				byte_mode_r <= 1'b1;
			end
			else if (BYTE_MODE_CLEAR_IN)
			begin
				byte_mode_r <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Registered port outputs
	always @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			DATA_OUT <= 16'h0000;
			DATA_OE_OUT <= 2'b00;
			SIXTEEN_BIT_IO_INDICATOR_N_OUT <= 1'b1;
			TF_INDEX_OUT <= 4'h0;
			TF_RD_OUT <= 1'b0;
			TF_WR_OUT <= 1'b0;
			TF_WR_LANES_OUT <= 2'b00;
			TF_WDATA_OUT <= 16'h0000;
			TF_ALT_OUT <= 1'b0;
			TF_CTRL_OUT <= 1'b0;
			CARD_RESET_OUT <= 1'b1;
			TRUE_IDE_OUT <= 1'b0;
			LEVEL_IRQ_OUT <= 1'b0;
			IRQ_OUT <= 1'b0;
			MAP_INDEX_OUT <= 6'h00;
			pulse_cnt_r <= 3'h0;
		end
		else
		begin
			DATA_OUT <= 16'h0000;
			DATA_OE_OUT <= 2'b00;
			TF_RD_OUT <= 1'b0;
			TF_WR_OUT <= 1'b0;
			TF_WR_LANES_OUT <= 2'b00;
			TF_ALT_OUT <= 1'b0;
			TF_CTRL_OUT <= 1'b0;
			TF_INDEX_OUT <= tf_idx;
			if (attr_rd)
			begin
				// Odd attribute bytes and the upper lane are undefined; zero is driven.
				DATA_OE_OUT <= {high_en, low_en};
				DATA_OUT <= {8'h00, attr_even ? (cor_hit ?
					{soft_reset_bit_r, level_interrupt_select_r, map_index_r} : CIS_DATA_IN) : 8'h00};
			end
			else if (card_tf_rd)
			begin
				DATA_OUT <= lane_rdata;
				DATA_OE_OUT <= lane_oe;
				TF_RD_OUT <= 1'b1;
			end
			else if (ide_rd)
			begin
				TF_RD_OUT <= 1'b1;
				TF_ALT_OUT <= ide_alt;
				TF_INDEX_OUT <= {1'b0, ADDR_IN[2:0]};
				DATA_OE_OUT <= (ide_data && !byte_mode_r) ? 2'b11 : 2'b01;
				DATA_OUT <= (ide_data && !byte_mode_r) ? {TF_ODD_DATA_IN, TF_EVEN_DATA_IN} :
					{8'h00, TF_EVEN_DATA_IN};
			end
			if (wr_fire && card_tf_wr)
			begin
				TF_WR_OUT <= 1'b1;
				TF_WR_LANES_OUT <= {lane_whi_en, !lane_wodd && low_en};
				TF_WDATA_OUT <= {lane_whi, lane_wodd ? 8'h00 : lane_wbyte};
				if (lane_wodd)
				begin
					TF_WR_LANES_OUT <= {1'b1, 1'b0};
					TF_WDATA_OUT <= {lane_wbyte, 8'h00};
				end
			end
			else if (wr_fire && ide_wr)
			begin
				TF_WR_OUT <= 1'b1;
				TF_CTRL_OUT <= ide_alt;
				TF_INDEX_OUT <= {1'b0, ADDR_IN[2:0]};
				TF_WR_LANES_OUT <= (ide_data && !byte_mode_r) ? 2'b11 : 2'b01;
				TF_WDATA_OUT <= DATA_IN;
			end
			SIXTEEN_BIT_IO_INDICATOR_N_OUT <= !((io_mode && !true_ide_r && tf_hit && attr && any_en &&
				!byte_mode_r) || (true_ide_r && !byte_mode_r && ide_data));
			CARD_RESET_OUT <= hard_reset;
			TRUE_IDE_OUT <= true_ide_r;
			LEVEL_IRQ_OUT <= level_interrupt_select_r;
			MAP_INDEX_OUT <= map_index_r;
			// Pulse style holds the event cycle plus the count, so the load is one short of the width.
			if (IRQ_EVENT_IN)
			begin
				pulse_cnt_r <= PULSE_CYC[2:0] - 3'h1;
			end
			else if (pulse_cnt_r != 3'h0)
			begin
				pulse_cnt_r <= pulse_cnt_r - 3'h1;
			end
			IRQ_OUT <= level_interrupt_select_r ? IRQ_ACTIVE_IN : (IRQ_EVENT_IN || pulse_cnt_r != 3'h0);
		end
	end
endmodule

/* File: tb/atad_chk_assertions.sv */
// Purpose: Port checker for the card host access decoder.
// Assumes: Every decoder output is registered; access outputs follow their inputs by one edge, MAP_INDEX_OUT and LEVEL_IRQ_OUT by two.
// Notes: Bound to each decoder instance below.
`timescale 1ns/100ps
module atad_chk
#(
	parameter AW = 11
)
(
	input wire CLK_IN,
	input wire RST_IN,
	input wire CARD_RESET_IN,
	input wire ATTR_SELECT_N_IN,
	input wire LOW_BYTE_CARD_ENABLE_N_IN,
	input wire HIGH_BYTE_CARD_ENABLE_N_IN,
	input wire OUTPUT_ENABLE_N_IN,
	input wire IO_READ_STROBE_N_IN,
	input wire IO_WRITE_STROBE_N_IN,
	input wire [AW-1:0] ADDR_IN,
	input wire [1:0] DATA_OE_OUT,
	input wire TF_WR_OUT,
	input wire TF_CTRL_OUT,
	input wire CARD_RESET_OUT,
	input wire TRUE_IDE_OUT,
	input wire LEVEL_IRQ_OUT,
	input wire [5:0] MAP_INDEX_OUT
);
	// ==========================================================================
	// Properties
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	wire lo = !LOW_BYTE_CARD_ENABLE_N_IN;
	wire hi = !HIGH_BYTE_CARD_ENABLE_N_IN;
	wire card = !TRUE_IDE_OUT && !CARD_RESET_OUT;
	property p_idle; !lo && !hi |=> DATA_OE_OUT == 2'b00; endproperty
	a_idle: assert property (p_idle) else $error("lanes driven while deselected");
	property p_attr_rd;
		card && !ATTR_SELECT_N_IN && !OUTPUT_ENABLE_N_IN && IO_READ_STROBE_N_IN && IO_WRITE_STROBE_N_IN
		&& lo && !hi |=> DATA_OE_OUT == 2'b01;
	endproperty
	a_attr_rd: assert property (p_attr_rd) else $error("attribute byte read lanes wrong");
	property p_io_rd;
		card && MAP_INDEX_OUT == 6'h01 && !ATTR_SELECT_N_IN && !IO_READ_STROBE_N_IN && IO_WRITE_STROBE_N_IN
		&& OUTPUT_ENABLE_N_IN && lo && hi |=> DATA_OE_OUT == 2'b11;
	endproperty
	a_io_rd: assert property (p_io_rd) else $error("word read did not drive both lanes");
	property p_wr_pulse; $rose(TF_WR_OUT) |=> !TF_WR_OUT; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse longer than one cycle");
	property p_hard; CARD_RESET_IN |=> CARD_RESET_OUT ##1 MAP_INDEX_OUT == 6'h00; endproperty
	a_hard: assert property (p_hard) else $error("hard reset did not clear the index");
	property p_ide_cfg; TRUE_IDE_OUT |-> MAP_INDEX_OUT == 6'h00 && !LEVEL_IRQ_OUT; endproperty
	a_ide_cfg: assert property (p_ide_cfg) else $error("configuration changed in IDE mode");
	property p_ide_both; TRUE_IDE_OUT && lo && hi |=> DATA_OE_OUT == 2'b00; endproperty
	a_ide_both: assert property (p_ide_both) else $error("both enables drove the bus");
	property p_ide_ctrl;
		TRUE_IDE_OUT && !lo && hi && ADDR_IN[2:0] == 3'h6 && IO_READ_STROBE_N_IN
		&& $fell(IO_WRITE_STROBE_N_IN) |=> TF_CTRL_OUT;
	endproperty
	a_ide_ctrl: assert property (p_ide_ctrl) else $error("control write not decoded");
endmodule
bind atad_decoder atad_chk #(.AW(AW)) u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CARD_RESET_IN(CARD_RESET_IN),
	.ATTR_SELECT_N_IN(ATTR_SELECT_N_IN), .LOW_BYTE_CARD_ENABLE_N_IN(LOW_BYTE_CARD_ENABLE_N_IN),
	.HIGH_BYTE_CARD_ENABLE_N_IN(HIGH_BYTE_CARD_ENABLE_N_IN), .OUTPUT_ENABLE_N_IN(OUTPUT_ENABLE_N_IN),
	.IO_READ_STROBE_N_IN(IO_READ_STROBE_N_IN), .IO_WRITE_STROBE_N_IN(IO_WRITE_STROBE_N_IN),
	.ADDR_IN(ADDR_IN), .DATA_OE_OUT(DATA_OE_OUT), .TF_WR_OUT(TF_WR_OUT), .TF_CTRL_OUT(TF_CTRL_OUT),
	.CARD_RESET_OUT(CARD_RESET_OUT), .TRUE_IDE_OUT(TRUE_IDE_OUT), .LEVEL_IRQ_OUT(LEVEL_IRQ_OUT),
	.MAP_INDEX_OUT(MAP_INDEX_OUT));

/* File: tb/atad_host.sv */
// Purpose: Host bus controller model driving the card strobes.
// Assumes: Control vector is {attr, ce2, ce1, oe, we, io_read_strobe_n, io_write_strobe_n}, all active low.
// Notes: Released data lines show the inverse of the last value so stale data never matches.
`timescale 1ns/100ps
module atad_host
(
	input wire clk_in,
	input wire [15:0] rdata_in,
	input wire [1:0] oe_in,
	input wire wr_in,
	input wire [1:0] lanes_in,
	input wire [15:0] wdata_in,
	output reg [6:0] ctl_out,
	output reg [10:0] addr_out,
	output reg [15:0] data_out,
	output reg card_rst_out,
	output wire [7:0] tf_even_out,
	output wire [7:0] tf_odd_out,
	output wire [7:0] cis_out
);
	reg ide;
	assign tf_even_out = 8'h3C;
	assign tf_odd_out = 8'hC3;
	assign cis_out = 8'h5A;
	initial
	begin
		ctl_out = 7'h7F;
		addr_out = 11'h000;
		data_out = 16'h0000;
		card_rst_out = 1'b0;
		ide = 1'b0;
	end
	// ==========================================================================
	// One access: held three edges, then one idle cycle so writes are re-armed.
	task acc(input [6:0] c, input [10:0] a, input [15:0] d, output [15:0] q, output [1:0] oe,
		output [2:0] w, output [15:0] wd);
	begin
		@(posedge clk_in);
		ctl_out <= c;
		addr_out <= a;
		data_out <= d;
		@(posedge clk_in);
		#1 w = {wr_in, lanes_in};
		wd = wdata_in;
		@(posedge clk_in);
		#1 q = rdata_in;
		oe = oe_in;
		@(posedge clk_in);
		ctl_out <= ide ? 7'h77 : 7'h7F;
		data_out <= ~d;
		@(posedge clk_in);
	end
	endtask
	// Output enable stays low across the reset pulse when IDE mode is wanted.
	task hreset(input i);
	begin
		@(posedge clk_in);
		card_rst_out <= 1'b1;
		ide <= i;
		ctl_out <= i ? 7'h77 : 7'h7F;
		repeat (3) @(posedge clk_in);
		card_rst_out <= 1'b0;
		repeat (3) @(posedge clk_in);
	end
	endtask
endmodule

/* File: tb/ata_card_host_access_decoder_tb.sv */
// Purpose: Self-checking bench for the card host access decoder.
// Assumes: Task file bytes from the host model are fixed at 3C even and C3 odd.
// Notes: Control write pulses and interrupt high cycles are counted and read side outputs captured on each read pulse, so none of these is missed.
`timescale 1ns/100ps
module ata_card_host_access_decoder_tb;
	reg clk;
	reg rst;
	integer err_count;
	integer num_checks;
	integer i;
	reg [15:0] q;
	reg [15:0] wd;
	reg [1:0] o;
	reg [2:0] w;
	wire [6:0] ctl;
	wire [10:0] addr;
	wire [15:0] hd;
	wire [15:0] rd;
	wire [15:0] twd;
	wire [1:0] oe;
	wire [1:0] ln;
	wire [7:0] te;
	wire [7:0] to;
	wire [7:0] card_info_structure;
	wire [5:0] map;
	wire tfwr;
	wire crin;
	wire crst;
	wire ide;
	wire levi;
	wire io16_n;
	wire tfrd;
	wire talt;
	wire tctl;
	wire irq;
	wire [3:0] tidx;
	reg bm_set;
	reg bm_clr;
	reg irq_ev;
	reg irq_act;
	reg rd_alt;
	reg rd_io16_n;
	reg [3:0] rd_idx;
	reg [15:0] ctl_cnt;
	reg [15:0] irq_cnt;
	atad_host u_host (.clk_in(clk), .rdata_in(rd), .oe_in(oe), .wr_in(tfwr), .lanes_in(ln), .wdata_in(twd),
		.ctl_out(ctl), .addr_out(addr), .data_out(hd), .card_rst_out(crin), .tf_even_out(te),
		.tf_odd_out(to), .cis_out(card_info_structure));
	atad_decoder u_dut (.CLK_IN(clk), .RST_IN(rst), .CARD_RESET_IN(crin), .ATTR_SELECT_N_IN(ctl[6]),
		.HIGH_BYTE_CARD_ENABLE_N_IN(ctl[5]), .LOW_BYTE_CARD_ENABLE_N_IN(ctl[4]), .OUTPUT_ENABLE_N_IN(ctl[3]),
		.WRITE_ENABLE_N_IN(ctl[2]), .IO_READ_STROBE_N_IN(ctl[1]), .IO_WRITE_STROBE_N_IN(ctl[0]),
		.ADDR_IN(addr), .DATA_IN(hd), .CIS_DATA_IN(card_info_structure), .TF_EVEN_DATA_IN(te), .TF_ODD_DATA_IN(to),
		.BYTE_MODE_SET_IN(bm_set), .BYTE_MODE_CLEAR_IN(bm_clr), .IRQ_EVENT_IN(irq_ev), .IRQ_ACTIVE_IN(irq_act),
		.DATA_OUT(rd), .DATA_OE_OUT(oe), .SIXTEEN_BIT_IO_INDICATOR_N_OUT(io16_n), .TF_INDEX_OUT(tidx),
		.TF_RD_OUT(tfrd), .TF_WR_OUT(tfwr), .TF_WR_LANES_OUT(ln), .TF_WDATA_OUT(twd), .TF_ALT_OUT(talt),
		.TF_CTRL_OUT(tctl), .CARD_RESET_OUT(crst), .TRUE_IDE_OUT(ide), .LEVEL_IRQ_OUT(levi), .MAP_INDEX_OUT(map),
		.IRQ_OUT(irq));
	// ==========================================================================
	// Capture of pulses and read side outputs
	always @(posedge clk)
	begin
		if (rst)
		begin
			ctl_cnt <= 16'h0000;
			irq_cnt <= 16'h0000;
		end
		else
		begin
			if (tctl)
				ctl_cnt <= ctl_cnt + 16'h0001;
			if (irq)
				irq_cnt <= irq_cnt + 16'h0001;
			if (tfrd)
			begin
				rd_idx <= tidx;
				rd_alt <= talt;
				rd_io16_n <= io16_n;
			end
		end
	end
	// ==========================================================================
	// Checking and closing
	task chk(input [15:0] got, input [15:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task final_report;
	begin
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// The whole sequence takes under two hundred cycles; the limit leaves wide margin.
	initial
	begin
		#50000;
		err_count = err_count + 1;
		final_report;
	end
	// ==========================================================================
	// Scenarios
	initial
	begin
		err_count = 0;
		num_checks = 0;
		rst = 1'b1;
		{bm_set, bm_clr, irq_ev, irq_act} = 4'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk({13'h0000, crst, oe}, 16'h0000);
		u_host.acc(7'h27, 11'h200, 16'h0000, q, o, w, wd);
		chk({6'h00, o, q[7:0]}, 16'h0100);
		u_host.acc(7'h2B, 11'h200, 16'h0041, q, o, w, wd);
		chk({9'h000, levi, map}, 16'h0041);
		irq_act <= 1'b1;
		repeat (3) @(posedge clk);
		irq_act <= 1'b0;
		repeat (2) @(posedge clk);
		chk(irq_cnt, 16'h0003);
		u_host.acc(7'h2B, 11'h201, 16'h00FF, q, o, w, wd);
		u_host.acc(7'h0B, 11'h200, 16'hC041, q, o, w, wd);
		u_host.acc(7'h27, 11'h200, 16'h0000, q, o, w, wd);
		chk({6'h00, o, q[7:0]}, 16'h0141);
		u_host.acc(7'h0D, 11'h000, 16'h0000, q, o, w, wd);
		chk(q, 16'hC33C);
		chk({15'h0000, rd_io16_n}, 16'h0000);
		u_host.acc(7'h2D, 11'h001, 16'h0000, q, o, w, wd);
		chk({6'h00, o, q[7:0]}, 16'h01C3);
		u_host.acc(7'h1D, 11'h001, 16'h0000, q, o, w, wd);
		chk({6'h00, o, q[15:8]}, 16'h02C3);
		u_host.acc(7'h0E, 11'h000, 16'hBEEF, q, o, w, wd);
		chk({13'h0000, w}, 16'h0007);
		chk(wd, 16'hBEEF);
		u_host.acc(7'h2E, 11'h001, 16'h0012, q, o, w, wd);
		chk({5'h00, w, wd[15:8]}, 16'h0612);
		for (i = 1; i < 4; i = i + 1)
		begin
			u_host.acc(7'h2B, 11'h200, i[15:0], q, o, w, wd);
			chk({10'h000, map}, i[15:0]);
			u_host.acc(7'h0D, (i == 1) ? 11'h120 : ((i == 2) ? 11'h1F0 : 11'h170), 16'h0000, q, o, w, wd);
			chk(q, 16'hC33C);
		end
		u_host.acc(7'h0D, 11'h1F0, 16'h0000, q, o, w, wd);
		chk({14'h0000, o}, 16'h0000);
		u_host.acc(7'h2B, 11'h200, 16'h00C3, q, o, w, wd);
		chk({9'h000, crst, map}, 16'h0040);
		u_host.acc(7'h2B, 11'h200, 16'h0000, q, o, w, wd);
		chk({9'h000, crst, map}, 16'h0000);
		u_host.acc(7'h47, 11'h000, 16'h0000, q, o, w, wd);
		chk(q, 16'hC33C);
		u_host.acc(7'h6B, 11'h000, 16'h0034, q, o, w, wd);
		chk({5'h00, w, wd[7:0]}, 16'h0534);
		u_host.acc(7'h2B, 11'h200, 16'h0002, q, o, w, wd);
		u_host.hreset(1'b1);
		chk({15'h0000, ide}, 16'h0001);
		chk({9'h000, crst, map}, 16'h0000);
		u_host.acc(7'h65, 11'h000, 16'h0000, q, o, w, wd);
		chk(q, 16'hC33C);
		chk({14'h0000, o}, 16'h0003);
		chk({15'h0000, rd_io16_n}, 16'h0000);
		u_host.acc(7'h55, 11'h006, 16'h0000, q, o, w, wd);
		chk({14'h0000, o}, 16'h0001);
		chk({11'h000, rd_alt, rd_idx}, 16'h0016);
		u_host.acc(7'h45, 11'h000, 16'h0000, q, o, w, wd);
		chk({14'h0000, o}, 16'h0000);
		u_host.acc(7'h56, 11'h006, 16'h00AA, q, o, w, wd);
		chk({5'h00, w, wd[7:0]}, 16'h05AA);
		chk(ctl_cnt, 16'h0001);
		bm_set <= 1'b1;
		@(posedge clk);
		bm_set <= 1'b0;
		u_host.acc(7'h65, 11'h000, 16'h0000, q, o, w, wd);
		chk({6'h00, o, q[7:0]}, 16'h013C);
		chk({15'h0000, rd_io16_n}, 16'h0001);
		bm_clr <= 1'b1;
		@(posedge clk);
		bm_clr <= 1'b0;
		u_host.acc(7'h65, 11'h000, 16'h0000, q, o, w, wd);
		chk({14'h0000, o}, 16'h0003);
		irq_ev <= 1'b1;
		@(posedge clk);
		irq_ev <= 1'b0;
		repeat (6) @(posedge clk);
		chk(irq_cnt, 16'h0007);
		u_host.acc(7'h27, 11'h200, 16'h0000, q, o, w, wd);
		chk({14'h0000, o}, 16'h0000);
		u_host.acc(7'h23, 11'h200, 16'h0041, q, o, w, wd);
		chk({9'h000, levi, map}, 16'h0000);
		final_report;
	end
endmodule
